/* ssp_pkg.sv */
// Functional notes
// RULE_01: enable plus valid mode claims port pins
// RULE_02: disable releases pins to general I/O
// RULE_03: slave clock is input from master
// RULE_04: select input routable to alternate pin
// RULE_05: mode 0100 honours active-low slave select
// RULE_06: select high holds reset, data tristated
// RULE_07: module reset clears the bit counter
// RULE_08: software reloads buffer after module reset
// RULE_09: clock edge set in slave needs select
// RULE_10: sleep keeps slave shifting, flags, wakes
// RULE_11: buffer write while busy sets collision
// RULE_12: slave byte onto full buffer overflows
// RULE_13: master mode never sets overflow
// RULE_14: polarity bit sets serial clock idle level
// RULE_15: modes 0-3 pick master bit rate
// RULE_16: mode 0101 slave ignores select pin
// RULE_17: sample phase picks middle or end
// RULE_18: software keeps sample phase clear in slave
// RULE_19: edge bit picks which clock edge stable
// RULE_20: buffer full shows completed received byte
// RULE_21: msb first, transmit and receive together
// RULE_22: software loads buffer before first clock
// RULE_23: buffer read clears buffer full
// RULE_24: overflow stops further slave communication
// RULE_25: pin-domain flags synchronised before use
package ssp_pkg;
    localparam int         ADDR_W    = 2;
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [1:0] STAT_ADDR = 2'h1;
    localparam logic [1:0] BUF_ADDR  = 2'h2;
    localparam logic [1:0] APF_ADDR  = 2'h3;

    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] STAT_RST  = 8'h00;
    localparam logic [7:0] APF_RST   = 8'h00;

    localparam int WRITE_COLLISION_FLAG_BIT  = 7;
    localparam int OVF_BIT   = 6;
    localparam int EN_BIT    = 5;
    localparam int CKP_BIT   = 4;
    localparam int SMP_BIT   = 7;
    localparam int CKE_BIT   = 6;
    localparam int BF_BIT    = 0;
    localparam int ROUTE_BIT = 0;

    localparam logic [3:0] MODE_DIV4     = 4'h0;
    localparam logic [3:0] MODE_DIV16    = 4'h1;
    localparam logic [3:0] MODE_DIV64    = 4'h2;
    localparam logic [3:0] MODE_TIMER_TWO     = 4'h3;
    localparam logic [3:0] MODE_SLV_SEL  = 4'h4;
    localparam logic [3:0] MODE_SLV_FREE = 4'h5;

    localparam int         DIV4_RATIO  = 4;
    localparam int         DIV16_RATIO = 16;
    localparam int         DIV64_RATIO = 64;
    localparam logic [5:0] DIV4_HALF   = 6'(DIV4_RATIO / 2 - 1);
    localparam logic [5:0] DIV16_HALF  = 6'(DIV16_RATIO / 2 - 1);
    localparam logic [5:0] DIV64_HALF  = 6'(DIV64_RATIO / 2 - 1);

    localparam logic [3:0] LAST_BIT     = 4'h7;
    localparam logic [4:0] MASTER_EDGES = 5'h10;

    typedef enum logic {MS_IDLE, MS_RUN} ssp_mstate_t;
endpackage

/* ssp_port.sv */
`timescale 1ns/1ps
module ssp_port (
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [1:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       sclk_in,
    output logic            sclk_out,
    output logic            sclk_oe_n_out,
    input  wire logic       sdi_in,
    output logic            sdo_out,
    output logic            sdo_oe_n_out,
    input  wire logic       sel_main_n_in,
    input  wire logic       sel_alt_n_in,
    input  wire logic       timer_two_tick_in,
    input  wire logic       sleep_in,
    input  wire logic       port_int_en_in,
    output logic            port_int_out,
    output logic            wake_out,
    output logic            pins_active_out,
    output logic            sel_pin_used_out
);
    // synchroniser lanes
    localparam int S_SCK = 3;
    localparam int S_SDI = 2;
    localparam int S_SM  = 1;
    localparam int S_SA  = 0;

    logic [5:0]         ctrl_reg;
    logic               write_collision_flag_reg;
    logic               ovf_reg;
    logic               bf_reg;
    logic               smp_reg;
    logic               cke_reg;
    logic               route_reg;
    logic [7:0]         buf_reg;
    logic [7:0]         tx_reg;
    logic [7:0]         rx_reg;
    logic [3:0]         bit_cnt_reg;
    logic               xfer_reg;
    logic               late_pend_reg;
    logic               rst_prev_reg;
    logic [3:0]         in_meta_reg;
    logic [3:0]         in_sync_reg;
    logic               sck_prev_reg;
    ssp_pkg::ssp_mstate_t mstate_reg;
    logic [5:0]         div_cnt_reg;
    logic [4:0]         edge_cnt_reg;
    logic [5:0]         half_lim;

    logic en;
    logic clock_polarity;
    logic [3:0] mode;
    logic is_master;
    logic is_slave;
    logic sel_hi;
    logic slv_hold;
    logic mod_rst;
    logic slv_act;
    logic mtick;
    logic m_edge;
    logic lead;
    logic trail;
    logic drive;
    logic samp_edge;
    logic late;
    logic sample;
    logic done;
    logic busy;
    logic buf_wr;
    logic buf_rd;
    logic ctrl_wr;
    logic accept;
    logic collide;

    assign en        = ctrl_reg[ssp_pkg::EN_BIT];
    assign clock_polarity       = ctrl_reg[ssp_pkg::CKP_BIT];
    assign mode      = ctrl_reg[3:0];
    assign is_master = en && (mode <= ssp_pkg::MODE_TIMER_TWO);
    assign is_slave  = en && (mode == ssp_pkg::MODE_SLV_SEL ||
                              mode == ssp_pkg::MODE_SLV_FREE);
    // select input after two flops, picked by route bit
    assign sel_hi    = route_reg ? in_sync_reg[S_SA]      // RULE_04
                                 : in_sync_reg[S_SM];
    assign slv_hold  = is_slave && mode == ssp_pkg::MODE_SLV_SEL
                       && sel_hi;                         // RULE_05
    assign mod_rst   = sys_rst_in || !en || slv_hold;     // RULE_07
    // overflow freezes the slave engine
    assign slv_act   = is_slave && !slv_hold && !ovf_reg; // RULE_24

    assign ctrl_wr = reg_wr_in && reg_addr_in == ssp_pkg::CTRL_ADDR;
    assign buf_wr  = reg_wr_in && reg_addr_in == ssp_pkg::BUF_ADDR;
    assign buf_rd  = reg_rd_in && reg_addr_in == ssp_pkg::BUF_ADDR;
    assign busy    = mstate_reg == ssp_pkg::MS_RUN || xfer_reg;
    assign collide = buf_wr && busy;                      // RULE_11
    assign accept  = buf_wr && !busy;

    always_comb begin
        case (mode)
            ssp_pkg::MODE_DIV4:  half_lim = ssp_pkg::DIV4_HALF;
            ssp_pkg::MODE_DIV16: half_lim = ssp_pkg::DIV16_HALF;
            default:             half_lim = ssp_pkg::DIV64_HALF;
        endcase
    end

    // master clock halts in sleep
    assign mtick = mstate_reg == ssp_pkg::MS_RUN && !sleep_in &&
                   (mode == ssp_pkg::MODE_TIMER_TWO ? timer_two_tick_in
                    : div_cnt_reg == half_lim);           // RULE_15
    assign m_edge = mtick && edge_cnt_reg < ssp_pkg::MASTER_EDGES;

    // slave edges from the synced pin, shifting in sleep
    always_comb begin
        lead  = 1'b0;
        trail = 1'b0;
        if (is_master) begin
            lead  = m_edge && !edge_cnt_reg[0];
            trail = m_edge && edge_cnt_reg[0];
        end else if (slv_act) begin                      // RULE_03 RULE_10
            lead  = in_sync_reg[S_SCK] != clock_polarity && sck_prev_reg == clock_polarity;
            trail = in_sync_reg[S_SCK] == clock_polarity && sck_prev_reg != clock_polarity;
        end
    end

    assign drive     = cke_reg ? trail : lead;            // RULE_19
    assign samp_edge = cke_reg ? lead : trail;
    assign late      = is_master && smp_reg;
    assign sample    = late ? (late_pend_reg && mtick)    // RULE_17
                            : samp_edge;
    assign done      = sample && bit_cnt_reg == ssp_pkg::LAST_BIT;

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            in_meta_reg  <= 4'hF;
            in_sync_reg  <= 4'hF;
            sck_prev_reg <= 1'b0;
        end else begin
            in_meta_reg  <= {sclk_in, sdi_in, sel_main_n_in,
                             sel_alt_n_in};
            in_sync_reg  <= in_meta_reg;                  // RULE_25
            sck_prev_reg <= in_sync_reg[S_SCK];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ctrl_reg  <= ssp_pkg::CTRL_RST[5:0];
            smp_reg   <= ssp_pkg::STAT_RST[ssp_pkg::SMP_BIT];
            cke_reg   <= ssp_pkg::STAT_RST[ssp_pkg::CKE_BIT];
            route_reg <= ssp_pkg::APF_RST[ssp_pkg::ROUTE_BIT];
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                ssp_pkg::CTRL_ADDR: begin
                    ctrl_reg <= reg_wdata_in[5:0];
                end
                ssp_pkg::STAT_ADDR: begin
                    smp_reg <= reg_wdata_in[ssp_pkg::SMP_BIT];
                    cke_reg <= reg_wdata_in[ssp_pkg::CKE_BIT];
                end
                ssp_pkg::APF_ADDR: begin
                    route_reg <= reg_wdata_in[ssp_pkg::ROUTE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // hardware set wins over a software clear
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            write_collision_flag_reg <= ssp_pkg::CTRL_RST[ssp_pkg::WRITE_COLLISION_FLAG_BIT];
            ovf_reg  <= ssp_pkg::CTRL_RST[ssp_pkg::OVF_BIT];
        end else begin
            if (collide) begin
                write_collision_flag_reg <= 1'b1;                         // RULE_11
            end else if (ctrl_wr) begin
                write_collision_flag_reg <= reg_wdata_in[ssp_pkg::WRITE_COLLISION_FLAG_BIT];
            end
            if (done && is_slave && bf_reg) begin
                ovf_reg <= 1'b1;                          // RULE_12 RULE_13
            end else if (ctrl_wr) begin
                ovf_reg <= reg_wdata_in[ssp_pkg::OVF_BIT];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            bf_reg  <= ssp_pkg::STAT_RST[ssp_pkg::BF_BIT];
            buf_reg <= 8'h00;
        end else begin
            if (done && !(is_slave && bf_reg)) begin
                bf_reg  <= 1'b1;                          // RULE_20
                buf_reg <= {rx_reg[6:0], in_sync_reg[S_SDI]};
            end else begin
                if (buf_rd) begin
                    bf_reg <= 1'b0;                       // RULE_23
                end
                if (accept) begin
                    buf_reg <= reg_wdata_in;
                end
            end
        end
    end

    // module reset seen last cycle, so only its entry or a system reset clears the transmit shifter
    always_ff @(posedge mclk_in) begin
        rst_prev_reg <= mod_rst;
    end

    // shift engine, msb first both ways
    always_ff @(posedge mclk_in) begin
        if (mod_rst) begin
            bit_cnt_reg   <= 4'h0;                        // RULE_07
            rx_reg        <= 8'h00;
            xfer_reg      <= 1'b0;
            late_pend_reg <= 1'b0;
            // a held slave may still be preloaded before select drops
            if (accept && !sys_rst_in) begin
                tx_reg  <= reg_wdata_in;
                sdo_out <= reg_wdata_in[7];
            end else if (sys_rst_in || !rst_prev_reg) begin
                tx_reg  <= 8'h00;                         // RULE_08
                sdo_out <= 1'b0;
            end
        end else begin
            if (accept) begin
                tx_reg  <= reg_wdata_in;                  // RULE_22
                sdo_out <= reg_wdata_in[7];
            end else if (drive) begin
                sdo_out <= cke_reg ? tx_reg[6] : tx_reg[7]; // RULE_21
                tx_reg  <= {tx_reg[6:0], 1'b0};
            end
            if (sample) begin
                rx_reg <= {rx_reg[6:0], in_sync_reg[S_SDI]};
                bit_cnt_reg <= done ? 4'h0 : bit_cnt_reg + 4'h1;
            end
            if (done) begin
                xfer_reg <= 1'b0;
            end else if (is_slave && (sample || (drive && !cke_reg))) begin
                xfer_reg <= 1'b1;
            end
            if (mtick) begin
                late_pend_reg <= samp_edge && late;
            end
        end
    end

    // master sequencer: 16 clock edges then a closing tick
    always_ff @(posedge mclk_in) begin
        if (mod_rst || !is_master) begin
            mstate_reg   <= ssp_pkg::MS_IDLE;
            div_cnt_reg  <= 6'h00;
            edge_cnt_reg <= 5'h00;
            sclk_out     <= clock_polarity;                          // RULE_14
        end else begin
            case (mstate_reg)
                ssp_pkg::MS_IDLE: begin
                    sclk_out     <= clock_polarity;                  // RULE_14
                    div_cnt_reg  <= 6'h00;
                    edge_cnt_reg <= 5'h00;
                    if (accept) begin
                        mstate_reg <= ssp_pkg::MS_RUN;
                    end
                end
                ssp_pkg::MS_RUN: begin
                    if (!sleep_in) begin
                        div_cnt_reg <= mtick ? 6'h00
                                             : div_cnt_reg + 6'h01;
                    end
                    if (m_edge) begin
                        sclk_out     <= !sclk_out;
                        edge_cnt_reg <= edge_cnt_reg + 5'h01;
                    end else if (mtick) begin
                        mstate_reg <= ssp_pkg::MS_IDLE;
                    end
                end
                default: begin
                    mstate_reg <= ssp_pkg::MS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            sclk_oe_n_out    <= 1'b1;
            sdo_oe_n_out     <= 1'b1;
            pins_active_out  <= 1'b0;
            sel_pin_used_out <= 1'b0;
            port_int_out     <= 1'b0;
            wake_out         <= 1'b0;
        end else begin
            sclk_oe_n_out    <= !is_master;               // RULE_02 RULE_03
            sdo_oe_n_out     <= !(is_master ||
                                  (is_slave && !slv_hold)); // RULE_06
            pins_active_out  <= is_master || is_slave;    // RULE_01
            sel_pin_used_out <= en &&
                                mode == ssp_pkg::MODE_SLV_SEL; // RULE_16
            port_int_out     <= done;                     // RULE_10
            wake_out         <= done && sleep_in && port_int_en_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                ssp_pkg::CTRL_ADDR: reg_rdata_out <=
                    {write_collision_flag_reg, ovf_reg, ctrl_reg};
                ssp_pkg::STAT_ADDR: reg_rdata_out <=
                    {smp_reg, cke_reg, 5'h00, bf_reg};
                ssp_pkg::BUF_ADDR:  reg_rdata_out <= buf_reg;
                default:            reg_rdata_out <= {7'h00, route_reg};
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_master_load;
        buf_wr && !busy && en && mode == ssp_pkg::MODE_DIV4 && !sleep_in;
    endsequence

    sequence s_byte_flagged;
        port_int_out ##0 bf_reg;
    endsequence

    a_pins_released: assert property ( // RULE_02
        !en && $past(!en) |-> sdo_oe_n_out && sclk_oe_n_out
                              && !pins_active_out)
        else $error("pins held while port disabled");

    a_slave_clk_in: assert property ( // RULE_03
        is_slave && $past(is_slave) |-> sclk_oe_n_out)
        else $error("slave drives serial clock");

    a_select_reset: assert property ( // RULE_06
        slv_hold |=> bit_cnt_reg == 4'h0 && sdo_oe_n_out)
        else $error("select high did not reset and float");

    a_write_collision_flag_sets: assert property ( // RULE_11
        collide && !mod_rst |=> write_collision_flag_reg
        && tx_reg == ($past(drive) ? {$past(tx_reg[6:0]), 1'b0}
                                   : $past(tx_reg)))
        else $error("collision not flagged or write taken");

    a_ovf_sets: assert property ( // RULE_12
        done && is_slave && bf_reg |=> ovf_reg
                                       && buf_reg == $past(buf_reg))
        else $error("overflow missed or buffer overwritten");

    a_ovf_slave_only: assert property ( // RULE_13
        $rose(ovf_reg) && !$past(ctrl_wr) |-> $past(is_slave))
        else $error("overflow set outside slave mode");

    a_idle_level: assert property ( // RULE_14
        is_master && mstate_reg == ssp_pkg::MS_IDLE
        && $past(mstate_reg == ssp_pkg::MS_IDLE) && $stable(clock_polarity)
        |-> sclk_out == clock_polarity)
        else $error("serial clock not at idle level");

    a_bf_clears: assert property ( // RULE_23
        buf_rd && !done |=> !bf_reg)
        else $error("buffer read left full flag set");

    a_done_flags: assert property ( // RULE_20
        done |=> s_byte_flagged)
        else $error("completed byte not flagged");

    a_div4_rate: assert property ( // RULE_15
        s_master_load ##1 !sleep_in [*8]
        |-> ##[20:40] port_int_out)
        else $error("fast master byte not completed in time");
endmodule

/* ssp_spi_master_model.sv */
`timescale 1ns/1ps
module ssp_spi_master_model #(
    parameter int HALF = 8
) (
    input  wire logic mclk_in,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_n_in,
    output logic      sclk_out,
    output logic      sdi_out,
    output logic      sel_n_out
);
    initial begin
        sclk_out  = 1'b0;
        sdi_out   = 1'b0;
        sel_n_out = 1'b1;
    end

    // released data line: no pull, so it wanders every cycle
    always @(posedge mclk_in) begin
        if (sel_n_out)
            sdi_out <= ~sdi_out;
    end

    // idle-low clock, data sampled on the leading (rising) edge
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        @(posedge mclk_in);
        sel_n_out <= 1'b0;
        repeat (HALF) @(posedge mclk_in);
        for (int i = 7; i > 7 - nbits; i--) begin
            sdi_out <= tx[i];
            repeat (HALF) @(posedge mclk_in);
            rx[i] = sdo_oe_n_in ? 1'bx : sdo_in;
            sclk_out <= 1'b1;
            repeat (HALF) @(posedge mclk_in);
            sclk_out <= 1'b0;
        end
        repeat (HALF) @(posedge mclk_in);
        sel_n_out <= 1'b1;
    endtask
endmodule

/* test_sync_serial_spi_port.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("Error %s expected %h seen %h", nm, e, g); \
    end \
end
module test_sync_serial_spi_port;
    logic       mclk_in, sys_rst_in, wr, rd, sleep, int_en, tick, tick_en;
    logic       route, sclk_out, sclk_oe_n, sdo, sdo_oe_n, p_int, wake;
    logic       pins, sel_used, m_sclk, m_sdi, m_sel_n, prev_clk;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, d, r;
    int         miscompares, n_tests, n_int, n_wake, n_tog, gap, run, tcnt;
    logic [7:0] rc[7] = '{8'h05, 8'h20, 8'h30, 8'h22, 8'h24, 8'h25, 8'h26};
    logic [3:0] rx[7] = '{4'h2, 4'h8, 4'h9, 4'h8, 4'hE, 4'hA, 4'h2};
    logic [7:0] mc[4] = '{8'h20, 8'h21, 8'h22, 8'h23};
    int         mh[4] = '{2, 8, 32, 5};
    logic [7:0] ms[4] = '{8'h40, 8'hC0, 8'h00, 8'h40};

    initial mclk_in = 1'b0;
    always #2.5 mclk_in = ~mclk_in;

    ssp_port DUT (
        .mclk_in          (mclk_in),
        .sys_rst_in       (sys_rst_in),
        .reg_addr_in      (addr),
        .reg_wdata_in     (wdata),
        .reg_wr_in        (wr),
        .reg_rd_in        (rd),
        .reg_rdata_out    (rdata),
        .sclk_in          (m_sclk),
        .sclk_out         (sclk_out),
        .sclk_oe_n_out    (sclk_oe_n),
        .sdi_in           (m_sdi),
        .sdo_out          (sdo),
        .sdo_oe_n_out     (sdo_oe_n),
        .sel_main_n_in    (route ? 1'b1 : m_sel_n),
        .sel_alt_n_in     (route ? m_sel_n : 1'b1),
        .timer_two_tick_in(tick),
        .sleep_in         (sleep),
        .port_int_en_in   (int_en),
        .port_int_out     (p_int),
        .wake_out         (wake),
        .pins_active_out  (pins),
        .sel_pin_used_out (sel_used)
    );

    ssp_spi_master_model #(.HALF(8)) master (
        .mclk_in    (mclk_in),
        .sdo_in     (sdo),
        .sdo_oe_n_in(sdo_oe_n),
        .sclk_out   (m_sclk),
        .sdi_out    (m_sdi),
        .sel_n_out  (m_sel_n)
    );

    // event counters and serial clock toggle spacing
    always @(posedge mclk_in) begin
        n_int  <= n_int + (p_int === 1'b1);
        n_wake <= n_wake + (wake === 1'b1);
        prev_clk <= sclk_out;
        if (sclk_out !== prev_clk) begin
            n_tog <= n_tog + 1;
            gap   <= run;
            run   <= 1;
        end else
            run <= run + 1;
        tick <= tick_en && (tcnt == 4);
        tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
    end

    task automatic wreg(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk_in);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [1:0] a, output logic [7:0] v);
        @(posedge mclk_in);
        rd <= 1'b1; addr <= a;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wait_int(input int target);
        int k;
        for (k = 0; k < 3000 && n_int < target; k++)
            @(posedge mclk_in);
        if (n_int < target) begin
            miscompares++;
            $display("Error wait for byte done expected pulse seen none");
            tally_and_finish();
        end else begin
            repeat (3) @(posedge mclk_in);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        int n0;
        {wr, rd, sleep, int_en, tick, tick_en, route, prev_clk} = '0;
        {addr, wdata, miscompares, n_tests, n_int, n_wake} = '0;
        {n_tog, gap, run, tcnt} = '0;
        sys_rst_in = 1'b1;
        repeat (5) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        rreg(ssp_pkg::CTRL_ADDR, d);
        `CHK("ctrl reset", ssp_pkg::CTRL_RST, d);
        rreg(ssp_pkg::STAT_ADDR, d);
        `CHK("status reset", ssp_pkg::STAT_RST, d);
        `CHK("pins reset", 3'b011, {pins, sdo_oe_n, sclk_oe_n});
        $display("test reset done");

        for (int i = 0; i < 7; i++) begin
            wreg(ssp_pkg::CTRL_ADDR, rc[i]);
            repeat (3) @(posedge mclk_in);
            `CHK("pin ownership", rx[i], {pins, sel_used, sclk_oe_n,
                 sclk_oe_n ? rx[i][0] : sclk_out});
            rreg(ssp_pkg::CTRL_ADDR, d);
            `CHK("ctrl readback", rc[i], d);
        end
        $display("test config table done");

        wreg(ssp_pkg::CTRL_ADDR, 8'h24);
        wreg(ssp_pkg::STAT_ADDR, 8'h40);
        wreg(ssp_pkg::BUF_ADDR, 8'hA5);
        n0 = n_int;
        master.xfer(8'h3C, 8, r);
        `CHK("slave sent", 8'hA5, r);
        wait_int(n0 + 1);
        rreg(ssp_pkg::STAT_ADDR, d);
        `CHK("status full", 8'h41, d);
        rreg(ssp_pkg::BUF_ADDR, d);
        `CHK("slave got", 8'h3C, d);
        rreg(ssp_pkg::STAT_ADDR, d);
        `CHK("status empty", 8'h40, d);
        $display("test slave byte done");

        wreg(ssp_pkg::BUF_ADDR, 8'h5A);
        n0 = n_int;
        master.xfer(8'h11, 8, r);
        master.xfer(8'h22, 8, r);
        wait_int(n0 + 2);
        rreg(ssp_pkg::CTRL_ADDR, d);
        `CHK("overflow set", 8'h64, d);
        rreg(ssp_pkg::BUF_ADDR, d);
        `CHK("first byte kept", 8'h11, d);
        master.xfer(8'h33, 8, r);
        repeat (10) @(posedge mclk_in);
        rreg(ssp_pkg::STAT_ADDR, d);
        `CHK("frozen after overflow", 8'h40, d);
        wreg(ssp_pkg::CTRL_ADDR, 8'h24);
        $display("test overflow done");

        wreg(ssp_pkg::BUF_ADDR, 8'h77);
        n0 = n_int;
        fork
            master.xfer(8'h44, 8, r);
            begin
                repeat (60) @(posedge mclk_in);
                wreg(ssp_pkg::BUF_ADDR, 8'hEE);
            end
        join
        `CHK("write ignored", 8'h77, r);
        wait_int(n0 + 1);
        rreg(ssp_pkg::CTRL_ADDR, d);
        `CHK("collision set", 8'hA4, d);
        rreg(ssp_pkg::BUF_ADDR, d);
        wreg(ssp_pkg::CTRL_ADDR, 8'h24);
        rreg(ssp_pkg::CTRL_ADDR, d);
        `CHK("collision cleared", 8'h24, d);
        $display("test collision done");

        wreg(ssp_pkg::BUF_ADDR, 8'hF0);
        master.xfer(8'h81, 3, r);
        repeat (4) @(posedge mclk_in);
        `CHK("data out floats", 1'b1, sdo_oe_n);
        wreg(ssp_pkg::BUF_ADDR, 8'hC3);
        n0 = n_int;
        master.xfer(8'h5E, 8, r);
        `CHK("sent after resync", 8'hC3, r);
        wait_int(n0 + 1);
        rreg(ssp_pkg::BUF_ADDR, d);
        `CHK("got after resync", 8'h5E, d);
        $display("test select resync done");

        route <= 1'b1;
        wreg(ssp_pkg::APF_ADDR, 8'h01);
        sleep  <= 1'b1;
        int_en <= 1'b1;
        wreg(ssp_pkg::BUF_ADDR, 8'h0F);
        n0 = n_int;
        master.xfer(8'hB4, 8, r);
        `CHK("alt select sent", 8'h0F, r);
        wait_int(n0 + 1);
        `CHK("wake pulses", 1, n_wake);
        rreg(ssp_pkg::BUF_ADDR, d);
        `CHK("sleep byte", 8'hB4, d);
        sleep <= 1'b0;
        $display("test sleep alt select done");

        for (int m = 0; m < 4; m++) begin
            tick_en <= (m == 3);
            wreg(ssp_pkg::CTRL_ADDR, mc[m]);
            wreg(ssp_pkg::STAT_ADDR, ms[m]);
            n0 = n_int;
            wreg(ssp_pkg::BUF_ADDR, 8'h69);
            n_tog = 0;
            if (m == 0)
                wreg(ssp_pkg::BUF_ADDR, 8'h00);
            wait_int(n0 + 1);
            // last toggle (for ms 8'h40 only) and closing half period follow the byte
            repeat (2 * mh[m] + 4) @(posedge mclk_in);
            `CHK("clock toggles", 16, n_tog);
            `CHK("half period", mh[m], gap);
            `CHK("clock idle", 1'b0, sclk_out);
            rreg(ssp_pkg::CTRL_ADDR, d);
            `CHK("no master overflow", 1'b0, d[6]);
            `CHK("master collision", m == 0, d[7]);
        end
        $display("test master rates done");
        tally_and_finish();
    end
endmodule
